// ===== verilog/cip_top.sv
`timescale 1ns/10ps
`include "cip_map.svh"

// ****************************************
// One controller of the cascaded pair
// ****************************************
module cip_core #(
   parameter bit IS_MASTER = 1'b1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Command port
   input cip_pkg::cip_cmd_s cmd,
   // Requests and trigger select
   input wire logic [7:0] irq_in,
   input wire logic [7:0] trig_sel,
   // Acknowledge events
   input wire logic ack_first,
   input wire logic ack_last,
   // Results
   output logic int_req,
   output logic [7:0] rd_data,
   output logic [7:0] vector,
   output logic cas_now,
   output logic [2:0] slave_id
);

   // Highest set bit, ranking from the level after low upward
   function automatic logic [3:0] pick(input logic [7:0] v, input logic [2:0] low);
      logic [3:0] r;
      logic [2:0] idx;
      r = 4'h0;
      for (int k = 7; k >= 0; k--) begin
         idx = low + 3'(k) + 3'h1;
         if (v[idx]) begin
            r = {1'b1, idx};
         end
      end
      return r;
   endfunction : pick

   // Rank of a level, zero is highest
   function automatic logic [2:0] rank(input logic [2:0] lvl, input logic [2:0] low);
      return 3'(lvl - low - 3'h1);
   endfunction : rank

   logic [7:0] edge_q;   // Latched rising edges
   logic [7:0] prev_q;   // Input one cycle ago
   logic [7:0] frz_q;    // Requests frozen for poll
   logic [7:0] isr_q;    // in_service_reg
   logic [7:0] imr_q;    // request_mask
   logic [2:0] low_q;    // Lowest priority level
   logic [4:0] base_q;   // Vector base
   logic [2:0] id_q;     // Cascade identity
   logic auto_end_of_service_q;         // auto_end_of_service
   logic sfnm_q;         // Special fully nested
   logic rot_auto_end_of_service_q;     // Rotate on automatic end
   logic poll_q;         // Poll pending
   logic ris_q;          // Status read selects in-service
   logic [2:0] win_q;    // Level taken at acknowledge
   logic spur_q;         // Acknowledge found nothing
   logic int_q;
   logic [7:0] rd_d;     // Read answer, zero outside a read
   logic [7:0] vec_q;
   cip_pkg::cip_init_e st_q;

   logic [7:0] req;
   logic [7:0] elig;
   logic [3:0] top_is;
   logic [3:0] top_rq;
   logic allow;
   logic init_wr;
   logic op_cmd_priority_word_wr;
   logic op_cmd_read_poll_word_wr;
   logic mask_wr;
   logic poll_rd;

   // ****************************************
   // Request qualification and resolution
   // ****************************************

   // Level inputs pass raw, edge inputs need a latched rise still held
   assign req = poll_q ? frz_q : ((trig_sel & irq_in) | (~trig_sel & edge_q & irq_in));
   assign elig = req & ~imr_q;
   assign top_is = pick(isr_q, low_q);
   assign top_rq = pick(elig, low_q);

   // Equal or lower levels stay blocked behind the top in-service bit, except level 2 on a master with special nesting
   always_comb begin
      allow = 1'b0;
      if (top_rq[3]) begin
         if (!top_is[3]) begin
            allow = 1'b1;
         end else if (rank(top_rq[2:0], low_q) < rank(top_is[2:0], low_q)) begin
            allow = 1'b1;
         end else if (IS_MASTER && sfnm_q && top_rq[2:0] == `CIP_CAS_LVL
                      && top_is[2:0] == `CIP_CAS_LVL) begin
            allow = 1'b1;
         end
      end
   end

   // Command decode
   assign init_wr = cmd.wr && !cmd.a0 && cmd.data[`CIP_INIT_BIT];
   assign op_cmd_priority_word_wr = cmd.wr && !cmd.a0 && !cmd.data[`CIP_INIT_BIT]
                    && !cmd.data[`CIP_OP_CMD_READ_POLL_WORD_BIT] && st_q == cip_pkg::ST_READY;
   assign op_cmd_read_poll_word_wr = cmd.wr && !cmd.a0 && !cmd.data[`CIP_INIT_BIT]
                    && cmd.data[`CIP_OP_CMD_READ_POLL_WORD_BIT] && st_q == cip_pkg::ST_READY;
   assign mask_wr = cmd.wr && cmd.a0 && st_q == cip_pkg::ST_READY;
   assign poll_rd = cmd.rd && !cmd.a0 && poll_q;
   assign cas_now = IS_MASTER && allow && top_rq[2:0] == `CIP_CAS_LVL;

   // ****************************************
   // Edge capture
   // ****************************************

   // Held still while a poll is pending so requests stay frozen
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         edge_q <= 8'h00;
         prev_q <= 8'h00;
      end else if (!poll_q) begin
         prev_q <= irq_in;
         // Only a rise sets; a held-high input raises no more
         edge_q <= (edge_q | (irq_in & ~prev_q)) & irq_in;
         if (ack_first && allow) begin
            edge_q[top_rq[2:0]] <= 1'b0;
         end
      end else if (poll_rd && allow) begin
         edge_q[top_rq[2:0]] <= 1'b0;
      end
   end

   // ****************************************
   // Init sequence and mode bits
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_q <= cip_pkg::ST_READY;
         base_q <= 5'h00;
         id_q <= 3'h0;
         auto_end_of_service_q <= 1'b0;
         sfnm_q <= 1'b0;
      end else if (init_wr) begin
         // Level-trigger bit of the first word is not looked at
         st_q <= cip_pkg::ST_W2;
         auto_end_of_service_q <= 1'b0;
         sfnm_q <= 1'b0;
      end else if (cmd.wr && cmd.a0) begin
         unique case (st_q)
            cip_pkg::ST_W2: begin
               base_q <= cmd.data[7:3];
               st_q <= cip_pkg::ST_W3;
            end
            cip_pkg::ST_W3: begin
               id_q <= cmd.data[2:0];
               st_q <= cip_pkg::ST_W4;
            end
            cip_pkg::ST_W4: begin
               // Automatic end only ever sticks on the master
               auto_end_of_service_q <= IS_MASTER && cmd.data[`CIP_AUTO_END_OF_SERVICE_BIT];
               sfnm_q <= IS_MASTER && cmd.data[`CIP_SFNM_BIT];
               st_q <= cip_pkg::ST_READY;
            end
            cip_pkg::ST_READY: begin
               st_q <= cip_pkg::ST_READY;
            end
         endcase
      end
   end

   // ****************************************
   // Mask register
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_n || init_wr) begin
         imr_q <= 8'h00;
      end else if (mask_wr) begin
         imr_q <= cmd.data;
      end
   end

   // ****************************************
   // Read/poll word and poll freeze
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_n || init_wr) begin
         poll_q <= 1'b0;
         ris_q <= 1'b0;
         frz_q <= 8'h00;
      end else if (op_cmd_read_poll_word_wr) begin
         poll_q <= cmd.data[`CIP_POLL_BIT];
         frz_q <= req;
         ris_q <= cmd.data[`CIP_RIS_BIT];
      end else if (poll_rd) begin
         poll_q <= 1'b0;
      end
   end

   // ****************************************
   // In-service bits and rotation
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_n || init_wr) begin
         isr_q <= 8'h00;
         low_q <= `CIP_LOW_RST;
         rot_auto_end_of_service_q <= 1'b0;
      end else if ((ack_first || poll_rd) && allow) begin
         isr_q[top_rq[2:0]] <= 1'b1;
      end else if (ack_last && auto_end_of_service_q && !spur_q) begin
         // Trailing edge of the second strobe ends service
         isr_q[win_q] <= 1'b0;
         if (rot_auto_end_of_service_q) begin
            low_q <= win_q;
         end
      end else if (op_cmd_priority_word_wr) begin
         unique case (cmd.data[7:5])
            3'b001: begin
               if (top_is[3]) begin
                  isr_q[top_is[2:0]] <= 1'b0;
               end
            end
            3'b011: begin
               isr_q[cmd.data[2:0]] <= 1'b0;
            end
            3'b101: begin
               if (top_is[3]) begin
                  isr_q[top_is[2:0]] <= 1'b0;
                  low_q <= top_is[2:0];
               end
            end
            3'b100: begin
               rot_auto_end_of_service_q <= 1'b1;
            end
            3'b000: begin
               rot_auto_end_of_service_q <= 1'b0;
            end
            3'b110: begin
               low_q <= cmd.data[2:0];
            end
            3'b111: begin
               isr_q[cmd.data[2:0]] <= 1'b0;
               low_q <= cmd.data[2:0];
            end
            3'b010: begin
               isr_q <= isr_q;
            end
         endcase
      end
   end

   // ****************************************
   // Acknowledge capture and vector
   // ****************************************

   // A request gone by the first strobe yields the default level 7
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         win_q <= 3'h0;
         spur_q <= 1'b0;
         vec_q <= 8'h00;
      end else if (ack_first) begin
         win_q <= allow ? top_rq[2:0] : `CIP_SPUR_LVL;
         spur_q <= !allow;
         vec_q <= {base_q, allow ? top_rq[2:0] : `CIP_SPUR_LVL};
      end
   end

   // ****************************************
   // Interrupt line and read data
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         int_q <= 1'b0;
      end else begin
         int_q <= allow;
      end
   end

   // Zero unless addressed, so the pair's answers can simply be ORed
   always_comb begin
      rd_d = 8'h00;
      if (cmd.rd) begin
         if (cmd.a0) begin
            rd_d = imr_q;
         end else if (poll_q) begin
            rd_d = {allow, 4'h0, top_rq[2:0]};
         end else begin
            rd_d = ris_q ? isr_q : req;
         end
      end
   end

   assign int_req = int_q;
   assign rd_data = rd_d;
   assign vector = vec_q;
   assign slave_id = id_q;

endmodule : cip_core

// ****************************************
// Cascaded pair with I/O decode
// ****************************************
// How it works
// - Reset ranks level 0 highest, 7 lowest
// - Acknowledge takes top request, sets its bit
// - Bit clears on end command or auto end
// - Service blocks equal/lower, higher still interrupts
// - Special nesting lets in-service slave rearbitrate
// - Normal nesting blocks in-service slave input
// - Automatic rotation makes serviced level lowest
// - Rotate plus end: non-specific end, rotate
// - Rotate-on-auto-end set and cleared by command
// - Set priority makes given level lowest
// - Specific end with rotate clears and rotates
// - Poll: next read acknowledges, requests frozen
// - Master selects slave with cascade code 010
// - Slave drives vector for won cascade input
// - Init level-trigger bit ignored, edge default
// - Levels 0,1,2,8,13 fixed edge triggered
// - Edge mode: rising transition only
// - Level mode: high level, requester drops early
// - Early-dropped request gives level 7, no bit
// - Mask bit blocks its line; 2 blocks slave
// - Base write with bit 4 starts init
// - Non-specific end clears top in-service bit
// - Automatic end only on master
module cip_top (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Processor I/O port
   input wire logic [15:0] io_addr,
   input wire logic [7:0] io_wdata,
   input wire logic io_wr,
   input wire logic io_rd,
   output logic [7:0] io_rdata,
   output logic io_rdata_valid,
   // Acknowledge and vector bus
   input wire logic ack_strobe_n,
   output logic [7:0] data_out,
   output logic data_oe,
   // Request lines and processor interrupt
   input wire logic [15:0] irq_in,
   output logic cpu_irq_line,
   output logic [2:0] cas_bus
);

   // Hit on a base and base+1 pair
   function automatic logic hit(input logic [15:0] a, input logic [15:0] base);
      return a[15:1] == base[15:1];
   endfunction : hit

   // Lines that must stay edge triggered
   localparam logic [15:0] TRIG_FIXED = `CIP_TRIG_FIXED;

   cip_pkg::cip_cmd_s m_cmd;
   cip_pkg::cip_cmd_s s_cmd;
   cip_pkg::cip_ack_e ak_q;
   logic [15:0] trig_q;    // trigger_sel_high, trigger_sel_low
   logic ack_prev_q;
   logic ack_fall;
   logic ack_rise;
   logic m_first;
   logic m_last;
   logic s_sel;
   logic cas_sel_q;        // Slave owns this acknowledge
   logic m_int;
   logic s_int;
   logic m_cas;
   logic [7:0] m_rd;
   logic [7:0] s_rd;
   logic [7:0] m_vec;
   logic [7:0] s_vec;
   logic [2:0] s_id;
   logic [7:0] rdata_q;
   logic rvalid_q;
   logic [7:0] dout_q;
   logic doe_q;
   logic irq_q;
   logic [2:0] cas_q;

   // ****************************************
   // Address decode
   // ****************************************
   assign m_cmd = '{wr: io_wr && hit(io_addr, `CIP_MASTER_BASE),
                    rd: io_rd && hit(io_addr, `CIP_MASTER_BASE),
                    a0: io_addr[0], data: io_wdata};
   assign s_cmd = '{wr: io_wr && hit(io_addr, `CIP_SLAVE_BASE),
                    rd: io_rd && hit(io_addr, `CIP_SLAVE_BASE),
                    a0: io_addr[0], data: io_wdata};

   // ****************************************
   // Trigger select registers
   // ****************************************

   // Fixed-edge bits are forced to zero on every write
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         trig_q <= `CIP_TRIG_RST;
      end else if (io_wr && io_addr == `CIP_TRIG_LOW_ADDR) begin
         trig_q[7:0] <= io_wdata & ~TRIG_FIXED[7:0];
      end else if (io_wr && io_addr == `CIP_TRIG_HIGH_ADDR) begin
         trig_q[15:8] <= io_wdata & ~TRIG_FIXED[15:8];
      end
   end

   // ****************************************
   // Acknowledge strobe phases
   // ****************************************
   assign ack_fall = ack_prev_q && !ack_strobe_n;
   assign ack_rise = !ack_prev_q && ack_strobe_n;
   assign m_first = ack_fall && ak_q == cip_pkg::AK_IDLE;
   assign m_last = ack_rise && ak_q == cip_pkg::AK_SECOND;
   // Slave joins only when the master's code matches its identity
   assign s_sel = m_first && m_cas && `CIP_SLAVE_CODE == s_id;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ack_prev_q <= 1'b1;
         ak_q <= cip_pkg::AK_IDLE;
      end else begin
         ack_prev_q <= ack_strobe_n;
         if (m_first) begin
            ak_q <= cip_pkg::AK_FIRST;
         end else if (ack_fall && ak_q == cip_pkg::AK_FIRST) begin
            ak_q <= cip_pkg::AK_SECOND;
         end else if (m_last) begin
            ak_q <= cip_pkg::AK_IDLE;
         end
      end
   end

   // ****************************************
   // Cascade bus and vector drive
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cas_q <= 3'h0;
         cas_sel_q <= 1'b0;
         dout_q <= 8'h00;
         doe_q <= 1'b0;
      end else begin
         if (m_first) begin
            cas_q <= m_cas ? `CIP_SLAVE_CODE : 3'h0;
            cas_sel_q <= s_sel;
         end
         if (ack_fall && ak_q == cip_pkg::AK_FIRST) begin
            dout_q <= cas_sel_q ? s_vec : m_vec;
            doe_q <= 1'b1;
         end else if (m_last) begin
            doe_q <= 1'b0;
            cas_q <= 3'h0;
         end
      end
   end

   // ****************************************
   // Read data and interrupt output
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rvalid_q <= 1'b0;
         irq_q <= 1'b0;
         rdata_q <= 8'h00;
      end else begin
         rvalid_q <= m_cmd.rd || s_cmd.rd;
         irq_q <= m_int;
         rdata_q <= m_rd | s_rd;
      end
   end

   // ****************************************
   // The two controllers
   // ****************************************
   cip_core #(.IS_MASTER(1'b1)) u_master_ctrl (
      .clk(clk),
      .rst_n(rst_n),
      .cmd(m_cmd),
      .irq_in({irq_in[7:3], s_int, irq_in[1:0]}),
      .trig_sel(trig_q[7:0]),
      .ack_first(m_first),
      .ack_last(m_last),
      .int_req(m_int),
      .rd_data(m_rd),
      .vector(m_vec),
      .cas_now(m_cas),
      .slave_id()
   );

   cip_core #(.IS_MASTER(1'b0)) u_slave_ctrl (
      .clk(clk),
      .rst_n(rst_n),
      .cmd(s_cmd),
      .irq_in(irq_in[15:8]),
      .trig_sel(trig_q[15:8]),
      .ack_first(s_sel),
      .ack_last(m_last && cas_sel_q),
      .int_req(s_int),
      .rd_data(s_rd),
      .vector(s_vec),
      .cas_now(),
      .slave_id(s_id)
   );

   assign io_rdata = rdata_q;
   assign io_rdata_valid = rvalid_q;
   assign data_out = dout_q;
   assign data_oe = doe_q;
   assign cpu_irq_line = irq_q;
   assign cas_bus = cas_q;

endmodule : cip_top

// ===== verilog/cip_map.svh
`ifndef CIP_MAP_SVH
`define CIP_MAP_SVH

// ****************************************
// I/O addresses
// ****************************************
`define CIP_MASTER_BASE 16'h0020
`define CIP_SLAVE_BASE 16'h00A0
`define CIP_TRIG_LOW_ADDR 16'h04D0
`define CIP_TRIG_HIGH_ADDR 16'h04D1

// ****************************************
// Command word fields
// ****************************************
`define CIP_INIT_BIT 4
`define CIP_OP_CMD_READ_POLL_WORD_BIT 3
`define CIP_ROT_BIT 7
`define CIP_SL_BIT 6
`define CIP_EOS_BIT 5
`define CIP_POLL_BIT 2
`define CIP_RIS_BIT 0
`define CIP_AUTO_END_OF_SERVICE_BIT 1
`define CIP_SFNM_BIT 4

// ****************************************
// Reset values and fixed codes
// ****************************************
`define CIP_LOW_RST 3'h7
`define CIP_SPUR_LVL 3'h7
`define CIP_CAS_LVL 3'h2
`define CIP_SLAVE_CODE 3'h2
`define CIP_TRIG_RST 16'h0000
`define CIP_TRIG_FIXED 16'h2107

`endif

// ===== verilog/cip_pkg.sv
package cip_pkg;

   // ****************************************
   // Command strobe carried to each controller
   // ****************************************
   typedef struct packed {
      logic wr;
      logic rd;
      logic a0;
      logic [7:0] data;
   } cip_cmd_s;

   // Init word sequencing
   typedef enum logic [1:0] {
      ST_READY,
      ST_W2,
      ST_W3,
      ST_W4
   } cip_init_e;

   // Acknowledge strobe phase
   typedef enum logic [1:0] {
      AK_IDLE,
      AK_FIRST,
      AK_SECOND
   } cip_ack_e;

endpackage : cip_pkg

// ===== verif/cip_top_chk.sv
`timescale 1ns/10ps
// ****************************************
// Port checker of the cascaded pair
// ****************************************
module cip_top_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // I/O port
   input wire logic [15:0] io_addr,
   input wire logic [7:0] io_wdata,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_rdata,
   input wire logic io_rdata_valid,
   // Acknowledge and cascade
   input wire logic ack_strobe_n,
   input wire logic [7:0] data_out,
   input wire logic data_oe,
   input wire logic [2:0] cas_bus,
   // Requests
   input wire logic [15:0] irq_in,
   input wire logic cpu_irq_line
);
   // One clock domain, so one default for every check
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   a_clean_release: assert property (
      $rose(rst_n) |-> !cpu_irq_line && !data_oe && cas_bus == 3'h0)
      else $error("outputs not idle after reset");
   a_read_source: assert property (
      io_rdata_valid |-> $past(io_rd) && ($past(io_addr) inside
      {16'h0020, 16'h0021, 16'h00A0, 16'h00A1}))
      else $error("read answer without a mapped read");
   a_read_quiet: assert property (
      !io_rdata_valid |-> io_rdata == 8'h00)
      else $error("read data outside its answer cycle");
   a_cas_code: assert property (
      cas_bus != 3'h0 |-> cas_bus == 3'h2)
      else $error("cascade bus carries a foreign code");
   a_cas_start: assert property (
      $rose(cas_bus != 3'h0) |-> !$past(ack_strobe_n))
      else $error("slave selected outside an acknowledge");
   a_vec_start: assert property (
      $rose(data_oe) |-> !$past(ack_strobe_n))
      else $error("vector driven without a low strobe");
   a_vec_end: assert property (
      data_oe && $rose(ack_strobe_n) |-> ##[1:3] !data_oe)
      else $error("vector held too long");
   a_cas_end: assert property (
      $fell(data_oe) |-> cas_bus == 3'h0)
      else $error("cascade code outlives the vector");
   a_vec_hold: assert property (
      data_oe && $past(data_oe) |-> $stable(data_out))
      else $error("vector changed while driven");
endmodule : cip_top_chk

// ===== verif/cip_cpu.sv
`timescale 1ns/10ps
// ****************************************
// Processor core model
// ****************************************
module cip_cpu (
   // Clock
   input wire logic clk,
   // Requests toward the pair
   output logic [15:0] io_addr,
   output logic [7:0] io_wdata,
   output logic io_wr,
   output logic io_rd,
   output logic ack_strobe_n,
   // Answers from the pair
   input wire logic [7:0] io_rdata,
   input wire logic io_rdata_valid,
   input wire logic [7:0] data_out,
   input wire logic data_oe,
   input wire logic [2:0] cas_bus
);
   // Idle bus at time zero
   initial begin
      io_addr = 16'h0000;
      io_wdata = 8'h00;
      io_wr = 1'b0;
      io_rd = 1'b0;
      ack_strobe_n = 1'b1;
   end

   // One write pulse; data inverted after, so stale data is never trusted
   task wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      io_addr <= a;
      io_wdata <= d;
      io_wr <= 1'b1;
      @(posedge clk);
      io_wr <= 1'b0;
      io_wdata <= ~d;
   endtask : wr

   // One read pulse; the answer stands only in the next cycle
   task rd(input logic [15:0] a, output logic [7:0] d, output logic ok);
      @(posedge clk);
      io_addr <= a;
      io_rd <= 1'b1;
      @(posedge clk);
      io_rd <= 1'b0;
      #1;
      d = io_rdata;
      ok = io_rdata_valid;
   endtask : rd

   // Two low pulses of len cycles; len picks a prompt or a slow core
   task ack(input int len, output logic [7:0] v, output logic [2:0] c);
      int i;
      v = 8'h00;
      c = 3'h0;
      for (i = 0; i < 4 * len + 2; i++) begin
         @(posedge clk);
         ack_strobe_n <= !(i < len || (i >= 2 * len && i < 3 * len));
         #1;
         // Capture what the pair drives while it drives it
         if (data_oe) begin
            v = data_out;
         end
         if (cas_bus != 3'h0) begin
            c = cas_bus;
         end
      end
   endtask : ack
endmodule : cip_cpu

// ===== verif/tb_cascaded_irq_priority_modes.sv
`timescale 1ns/10ps
// ****************************************
// Testbench of the cascaded pair
// ****************************************
module tb_cascaded_irq_priority_modes;
   // Design connections
   logic clk;
   logic rst_n;
   logic [15:0] io_addr;
   logic [7:0] io_wdata;
   logic io_wr;
   logic io_rd;
   logic [7:0] io_rdata;
   logic io_rdata_valid;
   logic ack_strobe_n;
   logic [7:0] data_out;
   logic data_oe;
   logic [15:0] irq_in;
   logic cpu_irq_line;
   logic [2:0] cas_bus;
   // Score and scratch
   int mismatches;
   int checked;
   logic [7:0] v;
   logic [7:0] d;
   logic [2:0] c;
   logic ok;

   cip_top i_cip_top (.clk(clk), .rst_n(rst_n), .io_addr(io_addr), .io_wdata(io_wdata),
      .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid),
      .ack_strobe_n(ack_strobe_n), .data_out(data_out), .data_oe(data_oe),
      .irq_in(irq_in), .cpu_irq_line(cpu_irq_line), .cas_bus(cas_bus));
   cip_cpu i_cip_cpu (.clk(clk), .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr),
      .io_rd(io_rd), .ack_strobe_n(ack_strobe_n), .io_rdata(io_rdata),
      .io_rdata_valid(io_rdata_valid), .data_out(data_out), .data_oe(data_oe),
      .cas_bus(cas_bus));

   // 10 MHz clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task chk(input string n, input logic [7:0] e, input logic [7:0] s);
      checked++;
      if (s !== e) begin
         $display("Error %s expected %h seen %h", n, e, s);
         mismatches++;
      end
   endtask : chk

   task w(input logic [15:0] a, input logic [7:0] x);
      i_cip_cpu.wr(a, x);
   endtask : w

   task r(input logic [15:0] a, input logic [7:0] e);
      i_cip_cpu.rd(a, d, ok);
      chk("read valid", 8'h01, {7'h00, ok});
      chk("read data", e, d);
   endtask : r

   task ak(input int len, input logic [7:0] e);
      i_cip_cpu.ack(len, v, c);
      chk("vector", e, v);
   endtask : ak

   // Long enough for the slave path to settle
   task lvl(input logic e);
      repeat (12) @(posedge clk);
      #1;
      chk("cpu_irq_line", {7'h00, e}, {7'h00, cpu_irq_line});
   endtask : lvl

   task req(input logic [15:0] x);
      @(posedge clk);
      irq_in <= x;
   endtask : req

   task ini(input logic [7:0] x);
      w(16'h0020, 8'h19);
      w(16'h0021, 8'h08);
      w(16'h0021, 8'h04);
      w(16'h0021, x);
   endtask : ini

   task t_init();
      ini(8'h01);
      w(16'h00A0, 8'h11);
      w(16'h00A1, 8'h70);
      w(16'h00A1, 8'h02);
      w(16'h00A1, 8'h01);
      r(16'h0021, 8'h00);
      i_cip_cpu.rd(16'h0030, d, ok);
      chk("unmapped valid", 8'h00, {7'h00, ok});
   endtask : t_init

   task t_nest();
      w(16'h0021, 8'h08);
      req(16'h0008);
      lvl(1'b0);
      r(16'h0021, 8'h08);
      w(16'h0021, 8'h00);
      lvl(1'b1);
      ak(2, 8'h0B);
      w(16'h0020, 8'h0B);
      r(16'h0020, 8'h08);
      req(16'h0028);
      lvl(1'b0);
      req(16'h002A);
      lvl(1'b1);
      ak(5, 8'h09);
      r(16'h0020, 8'h0A);
      w(16'h0020, 8'h20);
      r(16'h0020, 8'h08);
      w(16'h0020, 8'h20);
      lvl(1'b1);
      ak(2, 8'h0D);
      w(16'h0020, 8'h20);
      lvl(1'b0);
      req(16'h0000);
   endtask : t_nest

   task t_spur();
      req(16'h0010);
      lvl(1'b1);
      req(16'h0000);
      repeat (4) @(posedge clk);
      ak(2, 8'h0F);
      r(16'h0020, 8'h00);
   endtask : t_spur

   task t_slave();
      w(16'h0021, 8'h04);
      req(16'h0400);
      lvl(1'b0);
      w(16'h0021, 8'h00);
      lvl(1'b1);
      ak(2, 8'h72);
      chk("cas_bus", 8'h02, {5'h00, c});
      w(16'h00A0, 8'h0B);
      r(16'h00A0, 8'h04);
      req(16'h0600);
      lvl(1'b0);
      // Slave first, then master once the slave reads empty
      w(16'h00A0, 8'h20);
      r(16'h00A0, 8'h00);
      w(16'h0020, 8'h20);
      lvl(1'b1);
      ak(2, 8'h71);
      w(16'h00A0, 8'h20);
      w(16'h0020, 8'h20);
      req(16'h0000);
   endtask : t_slave

   task t_rot();
      w(16'h0020, 8'hC4);
      req(16'h0048);
      lvl(1'b1);
      ak(2, 8'h0E);
      w(16'h0020, 8'hA0);
      lvl(1'b1);
      ak(2, 8'h0B);
      w(16'h0020, 8'hA0);
      req(16'h00C9);
      lvl(1'b1);
      ak(2, 8'h0F);
      w(16'h0020, 8'hE7);
      lvl(1'b1);
      ak(2, 8'h08);
      w(16'h0020, 8'h20);
      r(16'h0020, 8'h00);
      req(16'h0000);
   endtask : t_rot

   task t_poll();
      req(16'h0020);
      lvl(1'b1);
      w(16'h0020, 8'h0C);
      r(16'h0020, 8'h85);
      w(16'h0020, 8'h0B);
      r(16'h0020, 8'h20);
      w(16'h0020, 8'h20);
      req(16'h0000);
   endtask : t_poll

   task t_level();
      w(16'h04D0, 8'h20);
      req(16'h0020);
      lvl(1'b1);
      ak(2, 8'h0D);
      w(16'h0020, 8'h20);
      lvl(1'b1);
      ak(2, 8'h0D);
      // Requester drops its level before the end command
      req(16'h0000);
      w(16'h0020, 8'h20);
      lvl(1'b0);
   endtask : t_level

   task t_modes();
      ini(8'h11);
      req(16'h0400);
      lvl(1'b1);
      ak(2, 8'h72);
      req(16'h0600);
      lvl(1'b1);
      ak(2, 8'h71);
      ini(8'h03);
      w(16'h0020, 8'h80);
      req(16'h0011);
      lvl(1'b1);
      ak(2, 8'h08);
      req(16'h0010);
      req(16'h0011);
      lvl(1'b1);
      ak(2, 8'h0C);
      ak(2, 8'h08);
      w(16'h0020, 8'h0B);
      r(16'h0020, 8'h00);
   endtask : t_modes

   task end_sim();
      $display("mismatches %0d checked %0d", mismatches, checked);
      if (mismatches == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_sim

   // Main sequence
   initial begin
      rst_n = 1'b0;
      irq_in = 16'h0000;
      mismatches = 0;
      checked = 0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      t_init();
      t_nest();
      t_spur();
      t_slave();
      t_rot();
      t_poll();
      t_level();
      t_modes();
      end_sim();
   end

   // Watchdog: the run needs well under a thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      end_sim();
   end
endmodule : tb_cascaded_irq_priority_modes

bind cip_top cip_top_chk i_cip_top_chk (.clk(clk), .rst_n(rst_n), .io_addr(io_addr),
   .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
   .io_rdata_valid(io_rdata_valid), .ack_strobe_n(ack_strobe_n), .data_out(data_out),
   .data_oe(data_oe), .cas_bus(cas_bus), .irq_in(irq_in), .cpu_irq_line(cpu_irq_line));
